// ---- hdl/hti_readout.sv ----
// Overview of operation
// (R1) slave only, standard and fast rates
// (R2) answer address 44 hex only
// (R3) master frames transfers with start, stop
// (R4) sample on rise, hold data while high
// (R5) seven address bits then direction bit
// (R6) eight bits plus acknowledge bit
// (R7) sleep until a measurement request
// (R8) write-direction address starts a measurement
// (R9) humidity, temperature, correct, update, sleep
// (R10) 14-bit values, most significant first
// (R11) read-direction address fetches, acknowledged
// (R12) keep sending until master not-acknowledges
// (R13) bytes one, two: status plus humidity
// (R14) bytes three, four: temperature, low bits undefined
// (R15) master may stop after byte two
// (R16) master may stop after byte three
// (R17) master waits or checks status bits
// (R18) cycle time set by resolution
// (R19) status 00 fresh, 01 already fetched
// (R20) output held between measurement cycles
module hti_readout #(
    parameter logic [31:0] MEAS_CYC_8  = hti_pkg::HTI_MEAS_CYC_8,
    parameter logic [31:0] MEAS_CYC_10 = hti_pkg::HTI_MEAS_CYC_10,
    parameter logic [31:0] MEAS_CYC_12 = hti_pkg::HTI_MEAS_CYC_12,
    parameter logic [31:0] MEAS_CYC_14 = hti_pkg::HTI_MEAS_CYC_14
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe,
    input  wire hti_pkg::hti_res_type res,
    input  wire logic [13:0]          hum_raw,
    input  wire logic [13:0]          temp_raw,
    output logic                      core_awake
);
    import hti_pkg::*;

    // serial engine states
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_TXACK
    } hti_sstate_type;

    logic [2:0]     scl_sy_r;   // scl synchroniser plus history
    logic [2:0]     sda_sy_r;   // sda synchroniser plus history
    logic           scl_rise;   // scl rising edge seen
    logic           scl_fall;   // scl falling edge seen
    logic           start_det;  // sda falls while scl high
    logic           stop_det;   // sda rises while scl high
    hti_sstate_type st_r;       // engine state
    logic [3:0]     bit_cnt_r;  // bits of current byte
    logic [7:0]     shift_r;    // received bits
    logic           rw_r;       // direction of this transfer
    logic           acked_r;    // master acknowledged last byte
    logic [2:0]     byte_idx_r; // next byte to send
    logic [7:0]     tx_r;       // byte being shifted out
    logic           sda_oe_r;   // pulling sda low
    logic           mr_r;       // measurement request pulse
    logic           df_r;       // data fetch pulse
    hti_result_type result;     // held measurement result
    logic           stale;      // result already fetched
    logic [7:0]     first_byte; // byte sent right after the address
    logic [7:0]     next_byte;  // byte sent after an acknowledge

    // result byte for a given position
    function automatic logic [7:0] byte_sel(input logic [2:0]     idx,
                                            input hti_result_type rv,
                                            input logic           stl);
        case (idx)
            3'h0:    byte_sel = {stl ? HTI_ST_STALE : HTI_ST_VALID,
                                 rv.hum[13:8]};          // [R13]
            3'h1:    byte_sel = rv.hum[7:0];             // [R13]
            3'h2:    byte_sel = rv.temp[13:6];           // [R14]
            3'h3:    byte_sel = {rv.temp[5:0], 2'h0};    // [R14]
            default: byte_sel = HTI_FILL_BYTE;
        endcase
    endfunction : byte_sel

    // measurement sequencer and output register
    hti_meas #(
        .MEAS_CYC_8  (MEAS_CYC_8),
        .MEAS_CYC_10 (MEAS_CYC_10),
        .MEAS_CYC_12 (MEAS_CYC_12),
        .MEAS_CYC_14 (MEAS_CYC_14)
    ) u_meas (
        .ref_clk             (ref_clk),
        .rst                 (rst),
        .measurement_request (mr_r),
        .data_fetch          (df_r),
        .res                 (res),
        .hum_raw             (hum_raw),
        .temp_raw            (temp_raw),
        .result_r            (result),
        .stale_r             (stale),
        .core_awake          (core_awake)
    );

    // two-flop synchronisers, third stage for edge history
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            scl_sy_r <= 3'h7;
            sda_sy_r <= 3'h7;
        end
        else
        begin
            scl_sy_r <= {scl_sy_r[1:0], scl_i};
            sda_sy_r <= {sda_sy_r[1:0], sda_i};
        end
    end

    // edge and condition detect on synchronised stages only
    assign scl_rise  = scl_sy_r[1] & ~scl_sy_r[2];                // [R4]
    assign scl_fall  = ~scl_sy_r[1] & scl_sy_r[2];
    assign start_det = scl_sy_r[1] & scl_sy_r[2]
                       & sda_sy_r[2] & ~sda_sy_r[1];              // [R3]
    assign stop_det  = scl_sy_r[1] & scl_sy_r[2]
                       & ~sda_sy_r[2] & sda_sy_r[1];              // [R3]
    assign first_byte = byte_sel(3'h0, result, stale);
    assign next_byte  = byte_sel(byte_idx_r, result, stale);

    // open-drain data: only ever pulls low
    assign sda_o  = 1'b0;
    assign sda_oe = sda_oe_r; // [R1]

    // serial slave engine
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_r       <= S_IDLE;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            rw_r       <= 1'b0;
            acked_r    <= 1'b0;
            byte_idx_r <= 3'h0;
            tx_r       <= 8'h00;
            sda_oe_r   <= 1'b0;
        end
        else if (start_det)
        begin
            // start or repeated start: collect address
            st_r      <= S_ADDR; // [R3] [R5]
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b0;
        end
        else if (stop_det)
        begin
            // stop ends any transfer
            st_r     <= S_IDLE; // [R3]
            sda_oe_r <= 1'b0;
        end
        else
        begin
            case (st_r)
                S_ADDR, S_RX:
                begin
                    // shift in on scl rise
                    if (scl_rise && bit_cnt_r < HTI_BYTE_BITS)
                    begin
                        shift_r   <= {shift_r[6:0], sda_sy_r[1]}; // [R4]
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_r == HTI_BYTE_BITS)
                    begin
                        if (st_r == S_RX)
                        begin
                            sda_oe_r <= 1'b1; // [R6]
                            st_r     <= S_ACK;
                        end
                        else if (shift_r[7:1] == HTI_SLAVE_ADDR) // [R2]
                        begin
                            sda_oe_r <= 1'b1; // [R6] [R11]
                            rw_r     <= shift_r[0]; // [R5]
                            st_r     <= S_ACK;
                        end
                        else
                            st_r <= S_IDLE; // [R2]
                    end
                end
                S_ACK:
                begin
                    // acknowledge clock over
                    if (scl_fall)
                    begin
                        bit_cnt_r <= 4'h0;
                        if (rw_r)
                        begin
                            tx_r       <= first_byte; // [R10]
                            sda_oe_r   <= ~first_byte[7];
                            byte_idx_r <= 3'h1;
                            st_r       <= S_TX;
                        end
                        else
                        begin
                            sda_oe_r <= 1'b0;
                            st_r     <= S_RX;
                        end
                    end
                end
                S_TX:
                begin
                    // next bit on scl fall, msb first
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == HTI_LAST_BIT)
                        begin
                            sda_oe_r <= 1'b0;
                            st_r     <= S_TXACK;
                        end
                        else
                        begin
                            tx_r      <= {tx_r[6:0], 1'b0}; // [R10]
                            sda_oe_r  <= ~tx_r[6];
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                S_TXACK:
                begin
                    // master answer sampled on rise
                    if (scl_rise)
                        acked_r <= ~sda_sy_r[1]; // [R6]
                    else if (scl_fall)
                    begin
                        bit_cnt_r <= 4'h0;
                        if (acked_r)
                        begin
                            // continue until a not-acknowledge
                            tx_r     <= next_byte; // [R12]
                            sda_oe_r <= ~next_byte[7];
                            if (byte_idx_r < HTI_BYTE_LAST)
                                byte_idx_r <= byte_idx_r + 3'h1;
                            st_r <= S_TX;
                        end
                        else
                            st_r <= S_IDLE; // [R12]
                    end
                end
                default:
                    st_r <= S_IDLE;
            endcase
        end
    end

    // request pulses to the sequencer
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mr_r <= 1'b0;
            df_r <= 1'b0;
        end
        else
        begin
            // write address accepted: measurement request
            mr_r <= (st_r == S_ADDR) && scl_fall && !start_det
                    && !stop_det && bit_cnt_r == HTI_BYTE_BITS
                    && shift_r == {HTI_SLAVE_ADDR, 1'b0}; // [R8]
            // read address accepted, first byte loaded: fetch
            df_r <= (st_r == S_ACK) && scl_fall && rw_r
                    && !start_det && !stop_det; // [R11] [R19]
        end
    end

endmodule : hti_readout

// ---- hdl/hti_pkg.sv ----
package hti_pkg;

    // fixed bus address of this sensor
    localparam logic [6:0]  HTI_SLAVE_ADDR = 7'h44;
    // bits in one serial byte
    localparam logic [3:0]  HTI_BYTE_BITS  = 4'h8;
    // bit index of the last data bit of a byte
    localparam logic [3:0]  HTI_LAST_BIT   = 4'h7;
    // index of the first byte after the fourth one
    localparam logic [2:0]  HTI_BYTE_LAST  = 3'h4;
    // filler sent after the four result bytes
    localparam logic [7:0]  HTI_FILL_BYTE  = 8'hFF;

    // status field codes
    localparam logic [1:0]  HTI_ST_VALID   = 2'h0;
    localparam logic [1:0]  HTI_ST_STALE   = 2'h1;

    // resolution codes
    localparam logic [1:0]  HTI_RES_8      = 2'h0;
    localparam logic [1:0]  HTI_RES_10     = 2'h1;
    localparam logic [1:0]  HTI_RES_12     = 2'h2;
    localparam logic [1:0]  HTI_RES_14     = 2'h3;

    // core clock rate
    localparam real         HTI_CLK_MHZ    = 250.0;
    // total measurement time, wake-up included, per resolution
    localparam real         HTI_T_MEAS_8_MS  = 1.4;
    localparam real         HTI_T_MEAS_10_MS = 2.9;
    localparam real         HTI_T_MEAS_12_MS = 10.0;
    localparam real         HTI_T_MEAS_14_MS = 35.0;
    // the same times in core clock cycles
    localparam logic [31:0] HTI_MEAS_CYC_8  =
        32'(int'(HTI_T_MEAS_8_MS * 1000.0 * HTI_CLK_MHZ));
    localparam logic [31:0] HTI_MEAS_CYC_10 =
        32'(int'(HTI_T_MEAS_10_MS * 1000.0 * HTI_CLK_MHZ));
    localparam logic [31:0] HTI_MEAS_CYC_12 =
        32'(int'(HTI_T_MEAS_12_MS * 1000.0 * HTI_CLK_MHZ));
    localparam logic [31:0] HTI_MEAS_CYC_14 =
        32'(int'(HTI_T_MEAS_14_MS * 1000.0 * HTI_CLK_MHZ));

    // one corrected result pair
    typedef struct packed {
        logic [13:0] hum;
        logic [13:0] temp;
    } hti_result_type;

    // resolution pair of both channels
    typedef struct packed {
        logic [1:0] hum;
        logic [1:0] temp;
    } hti_res_type;

endpackage : hti_pkg

// ---- hdl/hti_meas.sv ----
module hti_meas #(
    parameter logic [31:0] MEAS_CYC_8  = hti_pkg::HTI_MEAS_CYC_8,
    parameter logic [31:0] MEAS_CYC_10 = hti_pkg::HTI_MEAS_CYC_10,
    parameter logic [31:0] MEAS_CYC_12 = hti_pkg::HTI_MEAS_CYC_12,
    parameter logic [31:0] MEAS_CYC_14 = hti_pkg::HTI_MEAS_CYC_14
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic                    measurement_request,
    input  wire logic                    data_fetch,
    input  wire hti_pkg::hti_res_type    res,
    input  wire logic [13:0]             hum_raw,
    input  wire logic [13:0]             temp_raw,
    output hti_pkg::hti_result_type      result_r,
    output logic                         stale_r,
    output logic                         core_awake
);
    import hti_pkg::*;

    // sequencer phases
    typedef enum logic [1:0] {M_SLEEP, M_HUM, M_TEMP} hti_mstate_type;

    hti_mstate_type st_r;      // current phase
    logic [31:0]    cnt_r;     // cycles left in phase
    logic [31:0]    total;     // full cycle length
    logic [31:0]    half;      // humidity share
    logic [13:0]    hum_cap_r; // corrected humidity held for the end
    logic           done;      // last cycle of the measurement

    // time for one resolution code
    function automatic logic [31:0] res_cycles(input logic [1:0] r);
        case (r)
            HTI_RES_8:  res_cycles = MEAS_CYC_8;
            HTI_RES_10: res_cycles = MEAS_CYC_10;
            HTI_RES_12: res_cycles = MEAS_CYC_12;
            default:    res_cycles = MEAS_CYC_14;
        endcase
    endfunction : res_cycles

    // correction step: left-align to 14 bits
    function automatic logic [13:0] scale14(input logic [13:0] v,
                                            input logic [1:0]  r);
        case (r)
            HTI_RES_8:  scale14 = {v[7:0], 6'h00};
            HTI_RES_10: scale14 = {v[9:0], 4'h0};
            HTI_RES_12: scale14 = {v[11:0], 2'h0};
            default:    scale14 = v;
        endcase
    endfunction : scale14

    // slower channel sets the cycle length
    assign total = res_cycles((res.hum > res.temp) ? res.hum
                                                   : res.temp); // [R18]
    assign half  = total >> 1;
    assign done  = (st_r == M_TEMP) && (cnt_r <= 32'h0000_0001);
    // core only powered during a measurement
    assign core_awake = (st_r != M_SLEEP); // [R7]

    // phase sequencer: humidity, then temperature, then sleep
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_r      <= M_SLEEP;
            cnt_r     <= 32'h0000_0000;
            hum_cap_r <= 14'h0000;
        end
        else
        begin
            case (st_r)
                M_SLEEP:
                begin
                    // wake only on a request
                    if (measurement_request) // [R7] [R8]
                    begin
                        st_r  <= M_HUM;
                        cnt_r <= (half == 32'h0000_0000) ? 32'h0000_0001
                                                         : half;
                    end
                end
                M_HUM:
                begin
                    if (cnt_r <= 32'h0000_0001)
                    begin
                        // humidity conversion done first
                        hum_cap_r <= scale14(hum_raw, res.hum); // [R9] [R10]
                        st_r      <= M_TEMP;
                        cnt_r     <= total - half;
                    end
                    else
                        cnt_r <= cnt_r - 32'h0000_0001;
                end
                M_TEMP:
                begin
                    if (done)
                        st_r <= M_SLEEP; // [R9]
                    else
                        cnt_r <= cnt_r - 32'h0000_0001;
                end
                default:
                    st_r <= M_SLEEP;
            endcase
        end
    end

    // output register: changes only at the end of a cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            result_r <= '0;
        else if (done)
        begin
            result_r.hum  <= hum_cap_r;                   // [R9] [R20]
            result_r.temp <= scale14(temp_raw, res.temp); // [R10]
        end
    end

    // freshness flag: stale from power-on, fresh after update
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            stale_r <= 1'b1;  // [R19]
        else if (done)
            stale_r <= 1'b0;  // [R19]
        else if (data_fetch)
            stale_r <= 1'b1;  // [R19]
    end

endmodule : hti_meas

// ---- verif/hti_readout_monitor.sv ----
module hti_readout_monitor
    import hti_pkg::*;
#(
    parameter logic [31:0] MEAS_CYC_8  = HTI_MEAS_CYC_8,
    parameter logic [31:0] MEAS_CYC_10 = HTI_MEAS_CYC_10,
    parameter logic [31:0] MEAS_CYC_12 = HTI_MEAS_CYC_12,
    parameter logic [31:0] MEAS_CYC_14 = HTI_MEAS_CYC_14
) (
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic                 scl_i,
    input wire logic                 sda_i,
    input wire logic                 sda_o,
    input wire logic                 sda_oe,
    input wire hti_pkg::hti_res_type res,
    input wire logic                 core_awake
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [1:0]  top_res;     // slower of the two resolutions
    logic [31:0] exp_cyc;     // expected awake length
    logic [31:0] awake_cnt_r; // cycles awake so far
    logic [4:0]  scl_hi_r;    // cycles bus clock high, saturating

    assign top_res = (res.hum > res.temp) ? res.hum : res.temp;

    // measurement length picked by resolution
    always_comb
        case (top_res)
            HTI_RES_8:  exp_cyc = MEAS_CYC_8;
            HTI_RES_10: exp_cyc = MEAS_CYC_10;
            HTI_RES_12: exp_cyc = MEAS_CYC_12;
            default:    exp_cyc = MEAS_CYC_14;
        endcase

    // count awake cycles
    always_ff @(posedge ref_clk)
        if (rst || !core_awake)
            awake_cnt_r <= 32'h0000_0000;
        else
            awake_cnt_r <= awake_cnt_r + 32'h0000_0001;

    // count bus clock high time
    always_ff @(posedge ref_clk)
        if (rst || !scl_i)
            scl_hi_r <= 5'h00;
        else if (scl_hi_r != 5'h1F)
            scl_hi_r <= scl_hi_r + 5'h01;

    // bus clock went low a few cycles ago
    sequence scl_fell_lately;
        !scl_i && !$past(scl_i) && !$past(scl_i, 2) && ($past(scl_i, 3)
            || $past(scl_i, 4) || $past(scl_i, 5) || $past(scl_i, 6));
    endsequence
    // pull held for at least eight cycles
    sequence oe_hold;
        sda_oe [*8];
    endsequence

    a_drive_low_only: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !sda_oe && !core_awake)
        else $error("outputs active after reset");
    a_oe_after_fall: assert property ($changed(sda_oe)
        |-> scl_fell_lately)
        else $error("data pin changed outside clock low");
    a_oe_holds: assert property ($rose(sda_oe) |-> oe_hold)
        else $error("data pull too short");
    a_awake_cause: assert property ($rose(core_awake)
        |-> sda_oe && $past(sda_oe))
        else $error("wake without acknowledged request");
    a_awake_span: assert property ($fell(core_awake)
        |-> awake_cnt_r == exp_cyc)
        else $error("measurement length wrong");
    a_awake_holds: assert property (core_awake
        && (awake_cnt_r < exp_cyc - 32'h0000_0001) |=> core_awake)
        else $error("measurement ended early");
    a_idle_release: assert property (scl_hi_r > 5'h0C |-> !sda_oe)
        else $error("data pin held while bus idle");
    a_line_low: assert property (sda_oe |-> !sda_i)
        else $error("data pin pull not seen on line");
endmodule : hti_readout_monitor

bind hti_readout hti_readout_monitor #(
    .MEAS_CYC_8(MEAS_CYC_8), .MEAS_CYC_10(MEAS_CYC_10),
    .MEAS_CYC_12(MEAS_CYC_12), .MEAS_CYC_14(MEAS_CYC_14)
) hti_readout_monitor_i (
    .ref_clk(ref_clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .res(res), .core_awake(core_awake)
);

// ---- verif/hti_i2c_master.sv ----
module hti_i2c_master (
    output logic     scl,
    output logic     sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Q = 16; // quarter of a 64 ns bit

    // bus idle: clock high, data released
    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // data falls while clock high, off the core clock edges
    // clock raised first so a repeated start works from mid-byte
    task start();
        #1.5;
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask : start

    // data set in clock low, held while high
    task bit_io(input logic b, output logic r);
        #Q sda_low = ~b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
    endtask : bit_io

    // eight bits, most significant first
    task byte_io(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
    endtask : byte_io

    // data rises while clock high; clock then stands still
    task stop();
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask : stop
endmodule : hti_i2c_master

// ---- verif/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import hti_pkg::*;

    logic        ref_clk;
    logic        rst;
    hti_res_type res;
    logic [13:0] hum_raw;
    logic [13:0] temp_raw;
    logic        scl;
    logic        sda_low;
    wire logic   sda_line;
    logic        sda_o;
    logic        sda_oe;
    logic        core_awake;
    logic [27:0] exp_res;  // expected humidity and temperature
    logic [1:0]  rh;
    logic [1:0]  rt;
    logic        rs_ack;   // answer bits of an aborted address
    int          seed;
    int          n_errors;
    int          checks;

    // pulled-up wire: low if either side pulls
    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

    hti_readout #(
        .MEAS_CYC_8(32'h0000_0028), .MEAS_CYC_10(32'h0000_003C),
        .MEAS_CYC_12(32'h0000_0050), .MEAS_CYC_14(32'h0000_0064)
    ) hti_readout_i (
        .ref_clk(ref_clk), .rst(rst), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .res(res), .hum_raw(hum_raw),
        .temp_raw(temp_raw), .core_awake(core_awake)
    );
    hti_i2c_master mst_i (.scl(scl), .sda_low(sda_low), .sda(sda_line));

    // core clock, 4 ns
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // raw value widened to 14 bits
    function automatic logic [13:0] scale(input logic [1:0] rc,
                                          input logic [13:0] raw);
        return raw << (6 - 2 * rc);
    endfunction : scale

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task print_verdict();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // foreign address must stay unanswered
    task automatic wrong_addr(input logic [6:0] ad);
        logic [7:0] q;
        logic       a;
        if (ad == HTI_SLAVE_ADDR)
            ad = 7'h46;
        mst_i.start();
        mst_i.byte_io({ad, 1'b0}, q);
        mst_i.bit_io(1'b1, a);
        check(a, 1'b1);
        mst_i.stop();
        check(core_awake, 1'b0);
    endtask : wrong_addr

    // request a measurement and wait for it
    task automatic measure(input logic [1:0] h, input logic [1:0] t);
        logic [13:0] hr;
        logic [13:0] tr;
        logic [7:0]  q;
        logic        a;
        hr = 14'($random(seed)) >> (6 - 2 * h);
        tr = 14'($random(seed)) >> (6 - 2 * t);
        exp_res = {scale(h, hr), scale(t, tr)};
        @(posedge ref_clk);
        res      <= '{hum: h, temp: t};
        hum_raw  <= hr;
        temp_raw <= tr;
        mst_i.start();
        mst_i.byte_io({HTI_SLAVE_ADDR, 1'b0}, q);
        mst_i.bit_io(1'b1, a);
        check(a, 1'b0);
        check(core_awake, 1'b1);
        mst_i.byte_io(8'($random(seed)), q);
        mst_i.bit_io(1'b1, a);
        check(a, 1'b0);
        mst_i.stop();
        // wait for the cycle to end before fetching
        for (int k = 0; k < 400 && core_awake !== 1'b0; k++)
            @(posedge ref_clk);
        check(core_awake, 1'b0);
    endtask : measure

    // read n bytes, last one not acknowledged
    task automatic fetch(input int n, input logic [1:0] st,
                         input logic [27:0] rv);
        logic [39:0] e;
        logic [7:0]  q;
        logic [7:0]  m;
        logic        a;
        e = {st, rv, 2'b00, HTI_FILL_BYTE};
        mst_i.start();
        mst_i.byte_io({HTI_SLAVE_ADDR, 1'b1}, q);
        mst_i.bit_io(1'b1, a);
        check(a, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            mst_i.byte_io(8'hFF, q);
            mst_i.bit_io(i == n - 1, a);
            m = (i == 3) ? 8'hFC : 8'hFF;
            check(q & m, e[39 - 8 * i -: 8] & m);
        end
        mst_i.stop();
    endtask : fetch

    // main sequence
    initial
    begin
        seed     = 74405;
        n_errors = 0;
        checks   = 0;
        rst      = 1'b1;
        res      = '0;
        hum_raw  = '0;
        temp_raw = '0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check(core_awake, 1'b0);
        fetch(3, HTI_ST_STALE, '0);
        for (int k = 0; k < 6; k++)
        begin
            wrong_addr((k == 0) ? 7'h45 : 7'($random(seed)));
            rh = (k < 4) ? 2'(k) : 2'($random(seed));
            rt = 2'(3 * k);
            measure(rh, rt);
            fetch(5, HTI_ST_VALID, exp_res);
            fetch(2 + k % 2, HTI_ST_STALE, exp_res);
        end
        // aborted address, then repeated start and a fetch
        mst_i.start();
        repeat (4) mst_i.bit_io(1'b1, rs_ack);
        fetch(2, HTI_ST_STALE, exp_res);
        // second reset clears results, status stale
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        fetch(4, HTI_ST_STALE, '0);
        print_verdict();
    end

    // watchdog well beyond the expected run
    initial
    begin
        #150us;
        n_errors++;
        print_verdict();
    end
endmodule : tb_top
